// ---- dv/link_port_select_freq_counter_test.sv ----
// self-checking bench for lpsf_top
// assumes the bank model answers offsets at once
`timescale 1ns/10ps
module link_port_select_freq_counter_test;
	import lpsf_pkg::*;
	logic clk = 0, srst = 1, acc_valid = 0, acc_write = 0, dup_mode = 0, remote_req_b = 0, pix_clk_in = 0;
	lpsf_addr_t acc_dev_addr = 7'h00, base_bus_address = 7'h2C;
	lpsf_byte_t acc_reg_addr = 8'h00, acc_wdata = 8'h00, link_a_rdata, link_b_rdata, acc_rdata, bank_addr, bank_wdata;
	logic acc_ack, bank_a_we, bank_b_we, remote_fwd_b, secondary_address_enable, link_a_select, link_b_select;
	logic status_link_b, meter_busy;
	int err_total = 0, check_count = 0, n;
	// {steer, secondary, write, a_we, b_we, read from b}
	logic [7:0] rows [12] = '{8'h2C, 8'h4A, 8'h6E, 8'h08, 8'hEC, 8'hDA, 8'h20, 8'h41, 8'h61, 8'hE0, 8'hD1, 8'h00};
	always #5 clk = ~clk;
	// 28 ns pixel period, never on a rising clk edge
	always #14 pix_clk_in = ~pix_clk_in;
	lpsf_top u_dut (.clk, .srst, .acc_valid, .acc_dev_addr, .acc_write, .acc_reg_addr, .acc_wdata, .base_bus_address,
		.acc_ack, .acc_rdata, .link_a_rdata, .link_b_rdata, .bank_a_we, .bank_b_we, .bank_addr, .bank_wdata, .dup_mode,
		.remote_req_b, .remote_fwd_b, .secondary_address_enable, .link_a_select, .link_b_select, .status_link_b,
		.pix_clk_in, .meter_busy);
	lpsf_bank_model u_bank (.reg_addr(acc_reg_addr), .a_rdata(link_a_rdata), .b_rdata(link_b_rdata));
	task end_sim;
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string s, input lpsf_byte_t e, g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task acc(input lpsf_addr_t d, input logic w, input lpsf_byte_t r, v);
		@(posedge clk);
		acc_valid <= 1;
		acc_dev_addr <= d;
		acc_write <= w;
		acc_reg_addr <= r;
		acc_wdata <= v;
		@(posedge clk);
		acc_valid <= 0;
		#1;
	endtask
	task rst;
		srst <= 1;
		repeat (4) @(posedge clk);
		srst <= 0;
	endtask
	task meter(input lpsf_byte_t v);
		acc(base_bus_address, 1, 8'h1F, v);
		n = 0;
		while (meter_busy === 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		acc(base_bus_address, 0, 8'h1F, 8'h00);
	endtask
	initial begin
		#100000;
		err_total++;
		end_sim;
	end
	initial begin
		rst;
		// last row clears both selects before reading link A
		foreach (rows[i]) begin
			acc(base_bus_address, 1, 8'h1E, {5'h00, rows[i][7:5]});
			acc(base_bus_address + rows[i][4], rows[i][3], 8'h10, 8'h5A);
			chk("ack", 8'h01, {7'h00, acc_ack});
			chk("we", {6'h00, rows[i][2:1]}, {6'h00, bank_a_we, bank_b_we});
			chk("stat", {7'h00, rows[i][6] & ~rows[i][7]}, {7'h00, status_link_b});
			chk("sel", {5'h00, rows[i][7:5]}, {5'h00, secondary_address_enable, link_b_select, link_a_select});
			chk("addr", 8'h10, bank_addr);
			chk("wdat", 8'h5A, bank_wdata);
			if (!rows[i][3])
				chk("rd", rows[i][0] ? 8'hA0 : 8'hB0, acc_rdata);
		end
		rst;
		acc(base_bus_address, 0, 8'h1E, 8'h00);
		chk("steer", 8'h01, acc_rdata);
		acc(base_bus_address + 7'h01, 0, 8'h1F, 8'h00);
		chk("noack", 8'h00, {7'h00, acc_ack});
		dup_mode <= 1;
		remote_req_b <= 1;
		repeat (2) @(posedge clk);
		#1;
		chk("fwd", 8'h00, {7'h00, remote_fwd_b});
		acc(base_bus_address, 1, 8'h1E, 8'h04);
		repeat (2) @(posedge clk);
		#1;
		chk("fwd", 8'h01, {7'h00, remote_fwd_b});
		meter(8'd10);
		chk("win", 8'h01, {7'h00, n >= 40 && n <= 42});
		chk("cnt", 8'h01, {7'h00, acc_rdata >= 8'd13 && acc_rdata <= 8'd15});
		meter(8'd255);
		chk("sat", 8'hFF, acc_rdata);
		end_sim;
	end
endmodule

// ---- dv/lpsf_bank_model.sv ----
// link bank model: read data per offset, no latency
// assumes the design samples it in the cycle of acc_valid
`timescale 1ns/10ps
module lpsf_bank_model
	import lpsf_pkg::*;
(
	// offset in, bank data out
	input wire lpsf_byte_t reg_addr,
	output lpsf_byte_t a_rdata,
	output lpsf_byte_t b_rdata
);
	// distinct patterns so a wrong bank shows
	assign a_rdata = reg_addr ^ 8'hA0;
	assign b_rdata = reg_addr ^ 8'hB0;
endmodule

// ---- dv/lpsf_top_asserts.sv ----
// checker for steering and meter start on lpsf_top ports
// assumes bind onto lpsf_top, one clock domain
`timescale 1ns/10ps
module lpsf_chk
	import lpsf_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic srst,
	input wire logic acc_valid,
	input wire lpsf_addr_t acc_dev_addr,
	input wire logic acc_write,
	input wire lpsf_byte_t acc_reg_addr,
	input wire lpsf_byte_t acc_wdata,
	input wire lpsf_addr_t base_bus_address,
	input wire logic acc_ack,
	input wire logic bank_a_we,
	input wire logic bank_b_we,
	input wire logic secondary_address_enable,
	input wire logic link_a_select,
	input wire logic link_b_select,
	input wire logic meter_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic pri, sec, wb, sen;
	assign sen = secondary_address_enable;
	assign pri = acc_valid && acc_dev_addr == base_bus_address;
	assign sec = acc_valid && sen && acc_dev_addr == base_bus_address + 7'h01;
	// offsets 0x1E and 0x1F never reach a bank
	assign wb = acc_write && acc_reg_addr[7:1] != 7'h0F;
	chk_pri_ack: assert property (pri |=> acc_ack) else $error("primary not acked");
	chk_sec_ack: assert property (sec |=> acc_ack) else $error("secondary not acked");
	chk_foreign_ignored: assert property (acc_valid && !pri && !sec |=> !acc_ack) else $error("foreign acked");
	chk_sec_bank: assert property (sec && wb && !pri |=> bank_b_we && !bank_a_we) else $error("secondary bank");
	chk_b_write: assert property (pri && wb && !sen && link_b_select |=> bank_b_we) else $error("b write");
	chk_a_write: assert property (pri && wb && !sen && link_a_select |=> bank_a_we) else $error("a write");
	chk_sel_ignored: assert property (pri && wb && sen |=> bank_a_we && !bank_b_we) else $error("select used");
	chk_meter_start: assert property (acc_write && (pri || sec) && acc_reg_addr == 8'h1F && acc_wdata != 8'h00
		|=> meter_busy) else $error("meter idle");
	cover property (sec && wb);
	cover property (pri && wb && link_a_select && link_b_select);
	cover property ($fell(meter_busy));
endmodule
bind lpsf_top lpsf_chk u_chk (.clk, .srst, .acc_valid, .acc_dev_addr, .acc_write, .acc_reg_addr, .acc_wdata,
	.base_bus_address, .acc_ack, .bank_a_we, .bank_b_we, .secondary_address_enable, .link_a_select,
	.link_b_select, .meter_busy);

// ---- hw/lpsf_defines.svh ----
// offsets, field positions, reset values and timing counts for the link steering block
// assumes clk runs at 100 MHz and counts out one 40 ns local oscillator period per count unit
`ifndef LPSF_DEFINES_SVH
`define LPSF_DEFINES_SVH

`define LPSF_OFS_STEER 8'h1E
`define LPSF_OFS_METER 8'h1F
`define LPSF_BIT_LINK_A_SEL 0
`define LPSF_BIT_LINK_B_SEL 1
`define LPSF_BIT_SEC_ADDR_EN 2
`define LPSF_STEER_RESET 8'h01
`define LPSF_METER_RESET 8'h00
`define LPSF_SAT_MAX 8'hFF
`define LPSF_OSC_PERIOD_NS 40
`define LPSF_CLK_PERIOD_NS 10
`define LPSF_CYC_PER_COUNT ((`LPSF_OSC_PERIOD_NS + `LPSF_CLK_PERIOD_NS - 1) / `LPSF_CLK_PERIOD_NS)

`endif

// ---- hw/lpsf_pix_sync.sv ----
// pixel clock sampler: two-flop synchroniser and rising-edge pulse
// assumes pix_clk_in is an asynchronous level sampled on clk
`timescale 1ns/10ps
module lpsf_pix_sync (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// sampled pixel clock
	input wire logic pix_clk_in,
	// one-cycle pulse per rising edge
	output logic pix_edge
);
	logic sync_a;
	logic sync_b;
	logic sync_c;

	// first flop feeds only the second one
	always_ff @(posedge clk) begin
		if (srst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
			pix_edge <= 1'b0;
		end else begin
			sync_a <= pix_clk_in;
			sync_b <= sync_a;
			sync_c <= sync_b;
			pix_edge <= sync_b & ~sync_c;
		end
	end
endmodule

// ---- hw/lpsf_pkg.sv ----
// types shared by the link steering block
// assumes nothing beyond the defines header
package lpsf_pkg;
	typedef logic [7:0] lpsf_byte_t;
	typedef logic [6:0] lpsf_addr_t;
	typedef enum logic [0:0] {
		LPSF_METER_IDLE,
		LPSF_METER_COUNT
	} lpsf_meter_e;
endpackage

// ---- hw/lpsf_top.sv ----
// register steering and pixel clock meter behind decoded serial-bus accesses
// assumes an upstream serial slave presents one-cycle decoded accesses and that
// the external link banks return read data combinationally for acc_reg_addr in the access cycle
`timescale 1ns/10ps
`include "lpsf_defines.svh"
module lpsf_top
	import lpsf_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// decoded access from the serial slave
	input wire logic acc_valid,
	input wire lpsf_addr_t acc_dev_addr,
	input wire logic acc_write,
	input wire lpsf_byte_t acc_reg_addr,
	input wire lpsf_byte_t acc_wdata,
	input wire lpsf_addr_t base_bus_address,
	// answer to the serial slave
	output logic acc_ack,
	output lpsf_byte_t acc_rdata,
	// link bank ports
	input wire lpsf_byte_t link_a_rdata,
	input wire lpsf_byte_t link_b_rdata,
	output logic bank_a_we,
	output logic bank_b_we,
	output lpsf_byte_t bank_addr,
	output lpsf_byte_t bank_wdata,
	// remote forwarding on the second link
	input wire logic dup_mode,
	input wire logic remote_req_b,
	output logic remote_fwd_b,
	// steering state
	output logic secondary_address_enable,
	output logic link_a_select,
	output logic link_b_select,
	output logic status_link_b,
	// pixel clock meter
	input wire logic pix_clk_in,
	output logic meter_busy
);
	localparam logic [9:0] CYC_PER_COUNT = 10'(`LPSF_CYC_PER_COUNT);
	localparam lpsf_byte_t STEER_RESET = `LPSF_STEER_RESET;

	function automatic logic is_local(input lpsf_byte_t a);
		is_local = (a == `LPSF_OFS_STEER) || (a == `LPSF_OFS_METER);
	endfunction

	logic hit_pri;
	logic hit_sec;
	logic hit;
	logic steer_wr;
	logic meter_wr;
	logic bank_wr;
	logic next_we_a;
	logic next_we_b;
	logic next_rd_b;
	logic pix_edge;
	lpsf_meter_e meter_state;
	logic [9:0] interval_left;
	lpsf_byte_t pix_count;
	lpsf_byte_t meter_result;

	// second address is base plus one
	assign hit_pri = acc_dev_addr == base_bus_address;
	assign hit_sec = secondary_address_enable && (acc_dev_addr == 7'(base_bus_address + 7'h01));
	assign hit = acc_valid && (hit_pri || hit_sec);

	// writes to the two local registers never reach a bank
	assign steer_wr = hit && acc_write && (acc_reg_addr == `LPSF_OFS_STEER);
	assign meter_wr = hit && acc_write && (acc_reg_addr == `LPSF_OFS_METER);
	assign bank_wr = hit && acc_write && !is_local(acc_reg_addr);

	always_comb begin
		next_we_a = 1'b0;
		next_we_b = 1'b0;
		next_rd_b = 1'b0;
		if (hit_sec) begin
			next_we_b = 1'b1;
			next_rd_b = 1'b1;
		end else if (secondary_address_enable) begin
			// selects ignored, primary is link A
			next_we_a = 1'b1;
		end else begin
			next_we_a = link_a_select;
			next_we_b = link_b_select;
			// link A readable only with B clear
			next_rd_b = link_b_select;
		end
	end

	// steering register
	always_ff @(posedge clk) begin
		if (srst) begin
			link_a_select <= STEER_RESET[`LPSF_BIT_LINK_A_SEL];
			link_b_select <= STEER_RESET[`LPSF_BIT_LINK_B_SEL];
			secondary_address_enable <= STEER_RESET[`LPSF_BIT_SEC_ADDR_EN];
		end else if (steer_wr) begin
			link_a_select <= acc_wdata[`LPSF_BIT_LINK_A_SEL];
			link_b_select <= acc_wdata[`LPSF_BIT_LINK_B_SEL];
			secondary_address_enable <= acc_wdata[`LPSF_BIT_SEC_ADDR_EN];
		end
	end

	// bank steering and read answer
	always_ff @(posedge clk) begin
		if (srst) begin
			acc_ack <= 1'b0;
			acc_rdata <= 8'h00;
			bank_a_we <= 1'b0;
			bank_b_we <= 1'b0;
			bank_addr <= 8'h00;
			bank_wdata <= 8'h00;
		end else begin
			// bank data is taken in the access cycle, so banks need no wait
			acc_ack <= hit;
			bank_a_we <= bank_wr && next_we_a;
			bank_b_we <= bank_wr && next_we_b;
			if (hit) begin
				bank_addr <= acc_reg_addr;
				bank_wdata <= acc_wdata;
			end
			if (hit && !acc_write) begin
				// reserved bits 7:3 are not stored and read as zero
				if (acc_reg_addr == `LPSF_OFS_STEER)
					acc_rdata <= {5'h00, secondary_address_enable, link_b_select, link_a_select};
				else if (acc_reg_addr == `LPSF_OFS_METER)
					acc_rdata <= meter_result;
				else if (next_rd_b)
					acc_rdata <= link_b_rdata;
				else
					acc_rdata <= link_a_rdata;
			end
		end
	end

	// gate only: the forwarding path itself sits outside this block
	// duplicate mode needs the secondary enable
	// banked status view follows link B select while the secondary enable is clear
	always_ff @(posedge clk) begin
		if (srst) begin
			remote_fwd_b <= 1'b0;
			status_link_b <= 1'b0;
		end else begin
			remote_fwd_b <= remote_req_b && (!dup_mode || secondary_address_enable);
			status_link_b <= link_b_select && !secondary_address_enable;
		end
	end

	// three flops cost latency but keep metastability off the count
	// pixel clock synchronised into clk
	lpsf_pix_sync u_pix_sync (
		.clk(clk),
		.srst(srst),
		.pix_clk_in(pix_clk_in),
		.pix_edge(pix_edge)
	);

	// pixel clock meter; a new write restarts a running measurement
	always_ff @(posedge clk) begin
		if (srst) begin
			meter_state <= LPSF_METER_IDLE;
			interval_left <= 10'h000;
			pix_count <= 8'h00;
			meter_result <= `LPSF_METER_RESET;
			meter_busy <= 1'b0;
		end else if (meter_wr) begin
			interval_left <= 10'(acc_wdata * CYC_PER_COUNT);
			pix_count <= 8'h00;
			meter_state <= LPSF_METER_COUNT;
			meter_busy <= 1'b1;
		end else begin
			case (meter_state)
				LPSF_METER_IDLE: begin
					meter_busy <= 1'b0;
				end
				LPSF_METER_COUNT: begin
					// a zero length window ends here at once with count 0
					if (interval_left == 10'h000) begin
						meter_result <= pix_count;
						meter_state <= LPSF_METER_IDLE;
						meter_busy <= 1'b0;
					end else begin
						interval_left <= interval_left - 10'h001;
						if (pix_edge && pix_count != `LPSF_SAT_MAX)
							pix_count <= pix_count + 8'h01;
					end
				end
				// unreachable with two states; a safe return to idle
				default: begin
					meter_state <= LPSF_METER_IDLE;
					meter_busy <= 1'b0;
				end
			endcase
		end
	end
endmodule
